// ### hw/can_flag_pkg.sv
// Shared constants and types for the transceiver status flag block
package can_flag_pkg;

  // Clock period and documented or default filter times
  localparam int CLK_NS = 8;
  localparam int TXDTO_NS = 1_200_000;
  localparam int BUSDOM_NS = 1_400_000;
  localparam int UV_NS = 30_000;
  localparam int INHM_NS = 10_000;
  localparam int GOSLEEP_NS = 50_000;

  // Least times, rounded up to whole cycles
  localparam int TXDTO_CYC = (TXDTO_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSDOM_CYC = (BUSDOM_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_CYC = (UV_NS + CLK_NS - 1) / CLK_NS;
  localparam int INHM_CYC = (INHM_NS + CLK_NS - 1) / CLK_NS;
  localparam int GOSLEEP_CYC = (GOSLEEP_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W = 20;
  localparam logic [2:0] EDGE_LAST = 3'h3;

  // Register port
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_CTRL = 2'h2;
  localparam int CTRL_WAKE_EN_BIT = 0;
  localparam logic CTRL_WAKE_EN_RST = 1'h1;

  typedef enum logic [2:0] {
    m_sleep,
    m_standby,
    m_gosleep,
    m_normal,
    m_silent
  } mode_type;

  typedef struct packed {
    logic [5:0] bus_short;
    logic rx_pad;
    logic bus_dom;
    logic remote_wake;
    logic io_below;
    logic core_below;
    logic battery_ok;
    logic mode_select_b_n;
    logic mode_select_a;
    logic inhibit_mask_in;
    logic local_wake_in;
    logic tx_in;
  } pins_type;

  // Recessive tx, released rx pad, everything else low
  localparam logic [16:0] PINS_IDLE = 17'h0_0401;

  typedef struct packed {
    logic inh_latched;
    logic bus_stuck_dominant;
    logic tx_rx_short;
    logic tx_dominant_timeout;
    logic tx_clamped;
    logic bus_fault;
    logic battery_low;
    logic io_supply_low;
    logic core_supply_low;
    logic inhibit_mask_change;
    logic wake_source_local;
    logic wake_source_valid;
    logic wake_request;
    logic cold_start;
  } flags_type;

endpackage

// ### hw/can_status_flags.sv
// Status and fault flag logic of a CAN FD transceiver
//
// Added by the designer: strobed register access and the address map.
module can_status_flags #(
  parameter int TXDTO_CYC = can_flag_pkg::TXDTO_CYC,
  parameter int BUSDOM_CYC = can_flag_pkg::BUSDOM_CYC,
  parameter int UV_CYC = can_flag_pkg::UV_CYC,
  parameter int INHM_CYC = can_flag_pkg::INHM_CYC,
  parameter int GOSLEEP_CYC = can_flag_pkg::GOSLEEP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins and analogue comparators
  input wire can_flag_pkg::pins_type pins_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Pins towards the controller and bus driver
  output logic fault_out_n_o,
  output logic fault_out_oe_o,
  output logic rx_out_o,
  output logic driver_en_o
);

  localparam int PW = $bits(can_flag_pkg::pins_type);
  localparam int CW = can_flag_pkg::CNT_W;

  if (TXDTO_CYC < 1 || BUSDOM_CYC < 1 || UV_CYC < 1 || INHM_CYC < 1 ||
      GOSLEEP_CYC < 1 || TXDTO_CYC >= 2**CW || BUSDOM_CYC >= 2**CW ||
      UV_CYC >= 2**CW || INHM_CYC >= 2**CW || GOSLEEP_CYC >= 2**CW)
  begin : g_bad
    $error("Timer parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change taken when two and three agree
  logic [PW-1:0] s1_q, s2_q, s3_q, pin_q, prev_q;
  can_flag_pkg::pins_type p, pv;

  for (genvar i = 0; i < PW; i++)
  begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        s1_q[i] <= can_flag_pkg::PINS_IDLE[i];
        s2_q[i] <= can_flag_pkg::PINS_IDLE[i];
        s3_q[i] <= can_flag_pkg::PINS_IDLE[i];
        pin_q[i] <= can_flag_pkg::PINS_IDLE[i];
      end
      else
      begin
        s1_q[i] <= pins_i[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_q <= can_flag_pkg::PINS_IDLE;
    else
      prev_q <= pin_q;
  end

  assign p = can_flag_pkg::pins_type'(pin_q);
  assign pv = can_flag_pkg::pins_type'(prev_q);

  wire tx_rise = p.tx_in & ~pv.tx_in;
  wire tx_fall = ~p.tx_in & pv.tx_in;
  wire bat_rise = p.battery_ok & ~pv.battery_ok;
  wire bus_release = ~p.bus_dom & pv.bus_dom;
  wire remote_rise = p.remote_wake & ~pv.remote_wake;

  ////////////////////////////////////////////////////////////////////////
  // Registers and mode
  logic wake_en_q;
  can_flag_pkg::flags_type f_q, f_d;
  can_flag_pkg::mode_type mode_q, mode_d, req_mode;
  logic [CW-1:0] gs_cnt_q, core_cnt_q, io_cnt_q, inh_cnt_q;
  logic [CW-1:0] dto_cnt_q, txrx_cnt_q, dom_cnt_q;
  logic [2:0] src_cnt_q, bad_cnt_q, good_cnt_q;
  logic short_seen_q, ent_low_q, ent_norm_q;

  // Mode pins: a high with b_n high is normal, both low is standby
  always_comb
  begin
    unique case ({p.mode_select_a, p.mode_select_b_n})
      2'b11: req_mode = can_flag_pkg::m_normal;
      2'b01: req_mode = can_flag_pkg::m_silent;
      2'b10: req_mode = can_flag_pkg::m_gosleep;
      2'b00: req_mode = can_flag_pkg::m_standby;
    endcase
  end

  wire low_q = mode_q == can_flag_pkg::m_standby ||
               mode_q == can_flag_pkg::m_gosleep ||
               mode_q == can_flag_pkg::m_sleep;
  wire gs_done = gs_cnt_q == CW'(GOSLEEP_CYC);

  always_comb
  begin
    mode_d = req_mode;
    if (!p.battery_ok)
      mode_d = can_flag_pkg::m_standby;
    else if (f_q.core_supply_low || f_q.io_supply_low)
      mode_d = can_flag_pkg::m_sleep;
    else
    begin
      unique case (mode_q)
        can_flag_pkg::m_sleep:
          if (f_q.wake_request)
            mode_d = can_flag_pkg::m_standby;
          else if (req_mode != can_flag_pkg::m_normal &&
                   req_mode != can_flag_pkg::m_silent)
            mode_d = can_flag_pkg::m_sleep;
        can_flag_pkg::m_gosleep:
          if (req_mode == can_flag_pkg::m_gosleep)
          begin
            if (f_q.wake_request)
              mode_d = can_flag_pkg::m_standby;
            else if (gs_done)
              mode_d = can_flag_pkg::m_sleep;
            else
              mode_d = can_flag_pkg::m_gosleep;
          end
        default:
          if (req_mode == can_flag_pkg::m_gosleep && f_q.wake_request)
            mode_d = mode_q;
      endcase
    end
  end

  wire mode_chg = mode_d != mode_q;
  wire into_clr = mode_chg && mode_d != can_flag_pkg::m_silent;
  wire enter_norm = mode_chg && mode_d == can_flag_pkg::m_normal;
  wire leave_norm = mode_chg && mode_q == can_flag_pkg::m_normal;
  wire enter_sil = mode_chg && mode_d == can_flag_pkg::m_silent;
  wire act_q = mode_q == can_flag_pkg::m_normal ||
               mode_q == can_flag_pkg::m_silent;
  wire norm_q = mode_q == can_flag_pkg::m_normal;
  wire enter_act = mode_chg && !act_q &&
                   (mode_d == can_flag_pkg::m_normal ||
                    mode_d == can_flag_pkg::m_silent);

  ////////////////////////////////////////////////////////////////////////
  // Events
  wire local_wu = (p.local_wake_in ^ pv.local_wake_in) & wake_en_q;
  wire wake_set = (low_q & (local_wu | remote_rise)) | bat_rise;
  // A wake restarts the filters, so a stale full count must not set
  wire core_set = p.core_below && core_cnt_q == CW'(UV_CYC) &&
                  !wake_set;
  wire io_set = p.io_below && io_cnt_q == CW'(UV_CYC) &&
                !wake_set;
  wire uv_set = core_set | io_set;
  wire bus_bad = short_seen_q | (~p.tx_in & (|p.bus_short));
  wire txrx_cond = ~p.tx_in & ~p.rx_pad & rx_out_o;
  wire local_any = f_q.tx_clamped | f_q.tx_dominant_timeout |
                   f_q.tx_rx_short | f_q.bus_stuck_dominant;

  ////////////////////////////////////////////////////////////////////////
  // Flag next state: clears first, sets after so a set wins, then battery low clears all
  always_comb
  begin
    f_d = f_q;
    f_d.battery_low = 1'b0;
    if (enter_norm)
      f_d.cold_start = 1'b0;
    if (enter_norm || uv_set)
      f_d.wake_request = 1'b0;
    if (leave_norm || uv_set ||
        (norm_q && tx_fall && src_cnt_q == can_flag_pkg::EDGE_LAST))
      f_d.wake_source_valid = 1'b0;
    if (into_clr)
    begin
      f_d.inhibit_mask_change = 1'b0;
      f_d.tx_dominant_timeout = 1'b0;
      f_d.tx_rx_short = 1'b0;
      f_d.bus_stuck_dominant = 1'b0;
    end
    if (!p.core_below || wake_set)
      f_d.core_supply_low = 1'b0;
    if (!p.io_below || wake_set)
      f_d.io_supply_low = 1'b0;
    if (leave_norm || (norm_q && tx_rise && !bus_bad &&
        good_cnt_q == can_flag_pkg::EDGE_LAST))
      f_d.bus_fault = 1'b0;
    if (bat_rise || ((enter_act && p.tx_in) ||
        (act_q && p.tx_in && p.bus_dom)) &&
        !(f_q.tx_dominant_timeout | f_q.tx_rx_short |
          f_q.bus_stuck_dominant))
      f_d.tx_clamped = 1'b0;
    if (tx_rise)
      f_d.tx_dominant_timeout = 1'b0;
    if (tx_rise && p.bus_dom)
      f_d.tx_rx_short = 1'b0;
    if (bus_release)
      f_d.bus_stuck_dominant = 1'b0;

    if (wake_set)
      f_d.wake_request = 1'b1;
    if (wake_set && !f_q.wake_source_valid)
    begin
      f_d.wake_source_valid = 1'b1;
      f_d.wake_source_local = local_wu | bat_rise;
    end
    if (bat_rise)
      f_d.cold_start = 1'b1;
    if (core_set)
      f_d.core_supply_low = 1'b1;
    if (io_set)
      f_d.io_supply_low = 1'b1;
    if (mode_q == can_flag_pkg::m_silent && inh_cnt_q == CW'(INHM_CYC))
    begin
      f_d.inhibit_mask_change = 1'b1;
      f_d.inh_latched = p.inhibit_mask_in;
    end
    if (norm_q && tx_rise && bus_bad &&
        bad_cnt_q == can_flag_pkg::EDGE_LAST)
      f_d.bus_fault = 1'b1;
    if (enter_act && !p.tx_in)
      f_d.tx_clamped = 1'b1;
    if (act_q && !p.tx_in && dto_cnt_q == CW'(TXDTO_CYC))
      f_d.tx_dominant_timeout = 1'b1;
    if (act_q && txrx_cond && txrx_cnt_q == CW'(TXDTO_CYC - 1))
      f_d.tx_rx_short = 1'b1;
    if (act_q && p.bus_dom && dom_cnt_q == CW'(BUSDOM_CYC))
      f_d.bus_stuck_dominant = 1'b1;

    if (!p.battery_ok)
    begin
      f_d = '0;
      f_d.battery_low = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timers and edge counters
  function automatic logic [CW-1:0] tick(input logic run,
                                         input logic [CW-1:0] c,
                                         input int lim);
    tick = !run ? '0 : (c == CW'(lim)) ? c : c + CW'(1);
  endfunction

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gs_cnt_q <= '0;
      core_cnt_q <= '0;
      io_cnt_q <= '0;
      inh_cnt_q <= '0;
      dto_cnt_q <= '0;
      txrx_cnt_q <= '0;
      dom_cnt_q <= '0;
    end
    else
    begin
      gs_cnt_q <= tick(mode_q == can_flag_pkg::m_gosleep, gs_cnt_q,
                       GOSLEEP_CYC);
      core_cnt_q <= tick(p.core_below && !wake_set, core_cnt_q,
                         UV_CYC);
      io_cnt_q <= tick(p.io_below && !wake_set, io_cnt_q, UV_CYC);
      inh_cnt_q <= tick(mode_q == can_flag_pkg::m_silent &&
                        p.inhibit_mask_in != f_q.inh_latched &&
                        inh_cnt_q != CW'(INHM_CYC), inh_cnt_q,
                        INHM_CYC);
      dto_cnt_q <= tick(act_q && !p.tx_in, dto_cnt_q, TXDTO_CYC);
      txrx_cnt_q <= tick(act_q && txrx_cond, txrx_cnt_q, TXDTO_CYC);
      dom_cnt_q <= tick(act_q && p.bus_dom, dom_cnt_q, BUSDOM_CYC);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      src_cnt_q <= '0;
      bad_cnt_q <= '0;
      good_cnt_q <= '0;
      short_seen_q <= 1'b0;
    end
    else if (!norm_q)
    begin
      src_cnt_q <= '0;
      bad_cnt_q <= '0;
      good_cnt_q <= '0;
      short_seen_q <= 1'b0;
    end
    else
    begin
      if (tx_fall && f_q.wake_source_valid)
        src_cnt_q <= src_cnt_q + 3'h1;
      if (tx_rise)
      begin
        short_seen_q <= 1'b0;
        bad_cnt_q <= bus_bad ? bad_cnt_q + 3'h1 : 3'h0;
        good_cnt_q <= bus_bad ? 3'h0 : good_cnt_q + 3'h1;
      end
      else if (bus_bad)
        short_seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State, register port and pin outputs
  wire fault_low =
    (norm_q && ((f_q.wake_source_valid && f_q.wake_source_local) ||
                f_q.bus_fault)) ||
    (mode_q == can_flag_pkg::m_silent &&
     ((f_q.cold_start && ent_low_q) || f_q.inhibit_mask_change ||
      (local_any && ent_norm_q))) ||
    (mode_q == can_flag_pkg::m_standby && f_q.wake_request);

  wire [15:0] rd_sel =
    addr_i == can_flag_pkg::ADDR_STATUS ? 16'(f_q) :
    addr_i == can_flag_pkg::ADDR_MODE ? 16'(mode_q) :
    addr_i == can_flag_pkg::ADDR_CTRL ? 16'(wake_en_q) : 16'h0000;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_q <= can_flag_pkg::m_standby;
      f_q <= '0;
      ent_low_q <= 1'b0;
      ent_norm_q <= 1'b0;
      wake_en_q <= can_flag_pkg::CTRL_WAKE_EN_RST;
      rdata_o <= 16'h0000;
      fault_out_n_o <= 1'b1;
      fault_out_oe_o <= 1'b1;
      rx_out_o <= 1'b1;
      driver_en_o <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      f_q <= f_d;
      if (enter_sil)
      begin
        ent_low_q <= low_q;
        ent_norm_q <= norm_q;
      end
      if (wr_i && addr_i == can_flag_pkg::ADDR_CTRL)
        wake_en_q <= wdata_i[can_flag_pkg::CTRL_WAKE_EN_BIT];
      rdata_o <= rd_i ? rd_sel : 16'h0000;
      fault_out_n_o <= !fault_low;
      fault_out_oe_o <= mode_q != can_flag_pkg::m_sleep;
      rx_out_o <= !(f_q.wake_request && !act_q) && !p.bus_dom;
      driver_en_o <= norm_q && !(f_q.tx_clamped |
                     f_q.tx_dominant_timeout | f_q.tx_rx_short);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_gosleep_block: assert property (
    mode_q != can_flag_pkg::m_gosleep && f_q.wake_request |=>
    mode_q != can_flag_pkg::m_gosleep)
    else $error("Go-to-sleep entered with wake request");
  chk_sleep_release: assert property (
    mode_q == can_flag_pkg::m_sleep |=> !fault_out_oe_o)
    else $error("Fault output driven in sleep");
  chk_standby_wake: assert property (
    mode_q == can_flag_pkg::m_standby && f_q.wake_request |=>
    !fault_out_n_o && !rx_out_o)
    else $error("Wake request not shown in standby");
  chk_normal_clear: assert property (
    $rose(mode_q == can_flag_pkg::m_normal) |->
    !f_q.cold_start && !f_q.wake_request)
    else $error("Flags left set in normal mode");
  chk_battery_cold: assert property (
    $rose(p.battery_ok) |=> f_q.cold_start && f_q.wake_request)
    else $error("Battery recovery missed cold start");
  chk_battery_low: assert property (
    !p.battery_ok |=> f_q.battery_low && !f_q.bus_fault &&
    !f_q.tx_clamped && !f_q.wake_source_valid)
    else $error("Flags kept in battery undervoltage");
  chk_uv_filter: assert property (
    $rose(f_q.core_supply_low) |-> $past(core_cnt_q) == CW'(UV_CYC))
    else $error("Core supply flag set before filter time");
  chk_dto_driver: assert property (
    f_q.tx_dominant_timeout |=> !driver_en_o)
    else $error("Driver on during tx timeout");
  chk_bus_fault_pin: assert property (
    norm_q && f_q.bus_fault |=> !fault_out_n_o)
    else $error("Bus fault not shown in normal");
  chk_source_first: assert property (
    f_q.wake_source_valid && $past(f_q.wake_source_valid) |->
    $stable(f_q.wake_source_local))
    else $error("Wake source overwritten");

  cov_bus_fault: cover property ($rose(f_q.bus_fault));
  cov_silent_fault: cover property (
    mode_q == can_flag_pkg::m_silent && !fault_out_n_o);
  cov_sleep_wake: cover property (
    mode_q == can_flag_pkg::m_sleep ##[1:100]
    mode_q == can_flag_pkg::m_standby);

endmodule

// ### tb/can_ctrl_model.sv
// Controller-side pin model: transmit line, mode pins and inhibit mask
module can_ctrl_model (
  // Clock
  input wire logic clk_i,
  // From the transceiver
  input wire logic fault_n_i,
  // To the transceiver
  output logic tx_o,
  output logic mode_a_o,
  output logic mode_b_n_o,
  output logic inh_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    tx_o = 1'b1;
    mode_a_o = 1'b0;
    mode_b_n_o = 1'b0;
    inh_o = 1'b0;
  end

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_i);
    {mode_a_o, mode_b_n_o} <= m;
  endtask

  task automatic set_tx(input logic v);
    @(posedge clk_i);
    tx_o <= v;
  endtask

  // Slow edges so each one survives the input filter
  task automatic tx_falls(input int n);
    repeat (n)
    begin
      set_tx(1'b0);
      repeat (8) @(posedge clk_i);
      set_tx(1'b1);
      repeat (8) @(posedge clk_i);
    end
  endtask

  // Only a quiet fault line makes the later low an acknowledgement
  task automatic flip_mask();
    int n;
    n = 0;
    while (fault_n_i !== 1'b1 && n < 100)
    begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    inh_o <= ~inh_o;
  endtask
endmodule

// ### tb/can_status_flags_tb_top.sv
// Self-checking bench for the transceiver status flag block
module can_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Short timers keep the run brief
  localparam int TCYC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [5:0] bus_short = 6'h00;
  logic rx_pad = 1'b1;
  logic bus_dom = 1'b0;
  logic remote_wake = 1'b0;
  logic io_below = 1'b0;
  logic core_below = 1'b0;
  logic battery_ok = 1'b0;
  logic local_wake = 1'b0;
  logic tx;
  logic mode_a;
  logic mode_b_n;
  logic inh;
  logic [15:0] rdata_o;
  logic fault_out_n_o;
  logic fault_out_oe_o;
  logic rx_out_o;
  logic driver_en_o;
  can_flag_pkg::pins_type pins;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [15:0] v;

  assign pins = {bus_short, rx_pad, bus_dom, remote_wake, io_below,
    core_below, battery_ok, mode_b_n, mode_a, inh, local_wake, tx};

  always #4 clk_i = ~clk_i;

  can_status_flags #(
    .TXDTO_CYC(TCYC),
    .BUSDOM_CYC(TCYC),
    .UV_CYC(TCYC),
    .INHM_CYC(TCYC),
    .GOSLEEP_CYC(TCYC)
  ) can_status_flags_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(pins),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .fault_out_n_o(fault_out_n_o),
    .fault_out_oe_o(fault_out_oe_o),
    .rx_out_o(rx_out_o),
    .driver_en_o(driver_en_o)
  );

  can_ctrl_model can_ctrl_model_i (
    .clk_i(clk_i),
    .fault_n_i(fault_out_n_o),
    .tx_o(tx),
    .mode_a_o(mode_a),
    .mode_b_n_o(mode_b_n),
    .inh_o(inh)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic chk_stat(input logic [15:0] mask, input logic [15:0] exp);
    reg_rd(can_flag_pkg::ADDR_STATUS, v);
    chk("status", exp, v & mask);
  endtask

  task automatic chk_mode(input can_flag_pkg::mode_type m);
    reg_rd(can_flag_pkg::ADDR_MODE, v);
    chk("mode", {13'h0000, m}, v);
  endtask

  // Timeout guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_rd(2'h3, v);
    chk("unmapped", 16'h0000, v);
    reg_rd(can_flag_pkg::ADDR_CTRL, v);
    chk("ctrl reset", 16'h0001, v);
    reg_wr(can_flag_pkg::ADDR_CTRL, 16'h0000);
    reg_rd(can_flag_pkg::ADDR_CTRL, v);
    chk("ctrl", 16'h0000, v);
    reg_wr(can_flag_pkg::ADDR_CTRL, 16'h0001);
    $display("test registers done");
    // Cold start in standby
    battery_ok <= 1'b1;
    wait_c(12);
    chk_stat(16'h000F, 16'h000F);
    chk_bit("fault", 1'b0, fault_out_n_o);
    chk_bit("rx", 1'b0, rx_out_o);
    can_ctrl_model_i.set_mode(2'b01);
    wait_c(12);
    chk_bit("fault", 1'b0, fault_out_n_o);
    can_ctrl_model_i.set_mode(2'b10);
    wait_c(12);
    chk_mode(can_flag_pkg::m_silent);
    $display("test cold start done");
    can_ctrl_model_i.set_mode(2'b11);
    wait_c(12);
    chk_mode(can_flag_pkg::m_normal);
    chk_stat(16'h000F, 16'h000C);
    chk_bit("fault", 1'b0, fault_out_n_o);
    can_ctrl_model_i.tx_falls(4);
    wait_c(12);
    chk_stat(16'h0004, 16'h0000);
    chk_bit("fault", 1'b1, fault_out_n_o);
    $display("test wake source done");
    // Each of the six short detectors in turn
    for (int b = 0; b < 6; b++)
    begin
      bus_short <= 6'h01 << b;
      can_ctrl_model_i.tx_falls(4);
      wait_c(12);
      chk_stat(16'h0100, 16'h0100);
      chk_bit("fault", 1'b0, fault_out_n_o);
      chk_bit("driver", 1'b1, driver_en_o);
      bus_short <= 6'h00;
      can_ctrl_model_i.tx_falls(4);
      wait_c(12);
      chk_stat(16'h0100, 16'h0000);
      chk_bit("fault", 1'b1, fault_out_n_o);
    end
    $display("test bus fault done");
    can_ctrl_model_i.set_tx(1'b0);
    wait_c(40);
    chk_stat(16'h0400, 16'h0400);
    chk_bit("driver", 1'b0, driver_en_o);
    can_ctrl_model_i.set_tx(1'b1);
    wait_c(12);
    chk_stat(16'h0400, 16'h0000);
    chk_bit("driver", 1'b1, driver_en_o);
    $display("test tx timeout done");
    can_ctrl_model_i.set_mode(2'b01);
    wait_c(12);
    chk_bit("fault", 1'b1, fault_out_n_o);
    can_ctrl_model_i.flip_mask();
    wait_c(40);
    chk_stat(16'h0010, 16'h0010);
    chk_bit("fault", 1'b0, fault_out_n_o);
    can_ctrl_model_i.set_mode(2'b00);
    wait_c(12);
    chk_stat(16'h0010, 16'h0000);
    chk_bit("fault", 1'b1, fault_out_n_o);
    $display("test inhibit mask done");
    // Transmit held low across entry to the active mode
    can_ctrl_model_i.set_tx(1'b0);
    wait_c(2);
    can_ctrl_model_i.set_mode(2'b11);
    wait_c(8);
    chk_stat(16'h0200, 16'h0200);
    chk_bit("driver", 1'b0, driver_en_o);
    can_ctrl_model_i.set_tx(1'b1);
    bus_dom <= 1'b1;
    wait_c(40);
    chk_stat(16'h1200, 16'h1000);
    chk_bit("driver", 1'b1, driver_en_o);
    bus_dom <= 1'b0;
    wait_c(12);
    chk_stat(16'h1000, 16'h0000);
    $display("test clamp and bus dominant done");
    // Receive pad pulled low with transmit while rx is driven high
    rx_pad <= 1'b0;
    can_ctrl_model_i.set_tx(1'b0);
    wait_c(40);
    chk_stat(16'h0C00, 16'h0C00);
    chk_bit("driver", 1'b0, driver_en_o);
    bus_dom <= 1'b1;
    wait_c(2);
    can_ctrl_model_i.set_tx(1'b1);
    wait_c(8);
    chk_stat(16'h0C00, 16'h0000);
    chk_bit("driver", 1'b1, driver_en_o);
    bus_dom <= 1'b0;
    rx_pad <= 1'b1;
    $display("test tx rx short done");
    can_ctrl_model_i.set_mode(2'b10);
    wait_c(40);
    chk_mode(can_flag_pkg::m_sleep);
    chk_bit("fault enable", 1'b0, fault_out_oe_o);
    local_wake <= 1'b1;
    wait_c(12);
    chk_stat(16'h0002, 16'h0002);
    chk_mode(can_flag_pkg::m_standby);
    chk_bit("fault", 1'b0, fault_out_n_o);
    $display("test sleep and wake done");
    core_below <= 1'b1;
    wait_c(40);
    chk_stat(16'h0026, 16'h0020);
    chk_mode(can_flag_pkg::m_sleep);
    core_below <= 1'b0;
    wait_c(12);
    chk_stat(16'h0020, 16'h0000);
    local_wake <= 1'b0;
    wait_c(12);
    chk_stat(16'h000E, 16'h000E);
    io_below <= 1'b1;
    wait_c(40);
    chk_stat(16'h0046, 16'h0040);
    // Remote wake while the supply is still low: flag clears, filter restarts
    remote_wake <= 1'b1;
    wait_c(12);
    chk_stat(16'h004E, 16'h0006);
    chk_mode(can_flag_pkg::m_standby);
    io_below <= 1'b0;
    remote_wake <= 1'b0;
    can_ctrl_model_i.set_mode(2'b11);
    wait_c(12);
    chk_stat(16'h000C, 16'h0004);
    chk_bit("fault", 1'b1, fault_out_n_o);
    $display("test undervoltage done");
    battery_ok <= 1'b0;
    wait_c(12);
    chk_stat(16'hFFFF, 16'h0080);
    $display("test battery low done");
    stop_test();
  end
endmodule
